// >>> include/port_decode_cfg.svh
// Purpose: Constants for the I/O port select decoder
// Assumes: 8-bit I/O address, port offsets in the low three bits
// Notes:   Offsets are port numbers within the eight-port group
`ifndef PORT_DECODE_CFG_SVH
`define PORT_DECODE_CFG_SVH
`define CMD_STATUS_PORT_OFS 3'h0
`define TRACK_PORT_OFS      3'h1
`define SECTOR_PORT_OFS     3'h2
`define DATA_PORT_OFS       3'h3
`define AUX_CONTROL_PORT_OFS 3'h4
`define BASE_MSB            7
`define BASE_LSB            3
`define SEL_BIT             2
`define AUX_CODE_SEVEN      3'h0
`define AUX_CODE_SIX        3'h1
`define AUX_CODE_FIVE       3'h2
`endif

// >>> include/port_decode_pkg.sv
// Purpose: Types for the I/O port select decoder
// Assumes: Host bus strobes arrive unsynchronised; the decoder synchronises them
// Notes:   Bus signals travel together as one struct
package port_decode_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] dout;
      logic       dbin;
      logic       inp;
      logic       wr_n;
      logic       outp;
   } host_bus_t;
   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic [1:0] reg_sel;
      logic       aux_sel;
      logic [7:0] aux_dec_n;
      logic       drive_reset_n;
   } dec_state_t;
endpackage

// >>> core/io_port_select_decoder.sv
// Purpose: Board select and port decode for the disk controller host port
// Assumes: Host strobes come from pins and are synchronised here
// Notes:   Outputs are registered, so they lag the bus by five clocks: three sync stages, the agree step and the decode register
`timescale 1ns/1ps
`default_nettype none
`include "port_decode_cfg.svh"
// Contract
// - Compare address bits 7..3 with base switch
// - Mismatch selects nothing, cycle left alone
// - Each base value claims eight contiguous ports
// - Chip select when matched and bit 2 low
// - Offsets 0..3 reach controller's four registers
// - Address bits 1..0 passed straight to controller
// - Read only with data-in strobe and input status
// - Write only with write strobe and output status
// - Output to offset 4 enables code decoder
// - Only decoder outputs five to seven act
// - Decoder sees complemented data bits
// - Code 000 pulses the drive reset line
module io_port_select_decoder
   import port_decode_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       arst_n_in,
   // Host bus
   input  wire host_bus_t  bus_in,
   input  wire logic [4:0] base_sw_in,
   // Controller side
   output logic            ctrl_cs_n_out,
   output logic            ctrl_rd_n_out,
   output logic            ctrl_wr_n_out,
   output logic [1:0]      ctrl_reg_sel_out,
   // Auxiliary port
   output logic            aux_sel_out,
   output logic            decoder_out_five_n_out,
   output logic            decoder_out_six_n_out,
   output logic            decoder_out_seven_n_out,
   output logic            drive_reset_n_out
);
   typedef struct packed {
      host_bus_t  s1;
      host_bus_t  s2;
      host_bus_t  s3;
      logic [4:0] sw1;
      logic [4:0] sw2;
      logic [4:0] sw3;
      host_bus_t  bus;
      logic [4:0] base;
      dec_state_t dec;
   } state_t;

   localparam host_bus_t BUS_IDLE = '{addr: 8'h00, dout: 8'h00, dbin: 1'b0, inp: 1'b0, wr_n: 1'b1, outp: 1'b0};
   localparam dec_state_t DEC_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, reg_sel: 2'h0, aux_sel: 1'b0,
                                      aux_dec_n: 8'hFF, drive_reset_n: 1'b1};

   state_t state_r;
   state_t state_nxt;

   // One-hot active-low 3-to-8 decode with enable
   function automatic logic [7:0] dec3to8_n(input logic en, input logic [2:0] code);
      logic [7:0] v;
      v = 8'hFF;
      if (en) begin
         v[code] = 1'b0;
      end
      return v;
   endfunction

   always_comb begin
      logic       match;
      logic       rd_req;
      logic       wr_req;
      logic       aux_hit;
      logic [7:0] dec_n;
      state_nxt = state_r;
      // Three-stage sync; a change is taken only when stages two and three agree
      state_nxt.s1  = bus_in;
      state_nxt.s2  = state_r.s1;
      state_nxt.s3  = state_r.s2;
      state_nxt.sw1 = base_sw_in;
      state_nxt.sw2 = state_r.sw1;
      state_nxt.sw3 = state_r.sw2;
      if (state_r.s2 == state_r.s3) begin
         state_nxt.bus = state_r.s3;
      end
      if (state_r.sw2 == state_r.sw3) begin
         state_nxt.base = state_r.sw3;
      end
      // Low three bits are free, so one base value owns eight ports
      match   = (state_r.bus.addr[`BASE_MSB:`BASE_LSB] == state_r.base);
      rd_req  = state_r.bus.dbin && state_r.bus.inp;
      wr_req  = !state_r.bus.wr_n && state_r.bus.outp;
      aux_hit = match && (state_r.bus.addr[2:0] == `AUX_CONTROL_PORT_OFS) && wr_req;
      state_nxt.dec = DEC_IDLE;
      if (match && !state_r.bus.addr[`SEL_BIT]) begin
         state_nxt.dec.cs_n    = 1'b0;
         state_nxt.dec.rd_n    = !rd_req;
         state_nxt.dec.wr_n    = !wr_req;
         state_nxt.dec.reg_sel = state_r.bus.addr[1:0];
      end
      // Data-out lines are inverted on the board, so the decoder sees ~data
      dec_n = dec3to8_n(aux_hit, ~state_r.bus.dout[2:0]);
      state_nxt.dec.aux_sel = aux_hit;
      // Lower five outputs are not wired anywhere
      state_nxt.dec.aux_dec_n = {dec_n[7:5], 5'h1F};
      // Reset lasts as long as the output strobe; a real pulse stretch is the drive's job
      state_nxt.dec.drive_reset_n = dec_n[7];
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r <= '{s1: BUS_IDLE, s2: BUS_IDLE, s3: BUS_IDLE, sw1: 5'h00, sw2: 5'h00, sw3: 5'h00,
                      bus: BUS_IDLE, base: 5'h00, dec: DEC_IDLE};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign ctrl_cs_n_out           = state_r.dec.cs_n;
   assign ctrl_rd_n_out           = state_r.dec.rd_n;
   assign ctrl_wr_n_out           = state_r.dec.wr_n;
   assign ctrl_reg_sel_out        = state_r.dec.reg_sel;
   assign aux_sel_out             = state_r.dec.aux_sel;
   assign decoder_out_five_n_out  = state_r.dec.aux_dec_n[5];
   assign decoder_out_six_n_out   = state_r.dec.aux_dec_n[6];
   assign decoder_out_seven_n_out = state_r.dec.aux_dec_n[7];
   assign drive_reset_n_out       = state_r.dec.drive_reset_n;
endmodule
`default_nettype wire

// >>> test/io_port_select_decoder_monitor.sv
// Purpose: port decode checks
// Assumes: outputs settle within 8 quiet cycles
// Notes: bound by name to the decoder
`timescale 1ns/1ps
`default_nettype none
module io_port_select_decoder_monitor import port_decode_pkg::*; (
   input wire logic ref_clk_in, arst_n_in, ctrl_cs_n_out, ctrl_rd_n_out, ctrl_wr_n_out, aux_sel_out,
   input wire host_bus_t bus_in,
   input wire logic [4:0] base_sw_in,
   input wire logic [1:0] ctrl_reg_sel_out,
   input wire logic decoder_out_five_n_out, decoder_out_six_n_out, decoder_out_seven_n_out, drive_reset_n_out);
   wire logic hit = bus_in.addr[7:3] == base_sw_in;
   wire logic cs = hit && !bus_in.addr[2];
   wire logic [2:0] dec = {decoder_out_five_n_out, decoder_out_six_n_out, decoder_out_seven_n_out};
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   // Sync pipeline hides bus changes, so only long quiet spans are judged
   sequence settled; ($past(arst_n_in, 8) && $stable(bus_in) && $stable(base_sw_in))[*8]; endsequence
   chk_board_miss: assert property (settled ##0 !hit |-> ctrl_cs_n_out && !aux_sel_out)
      else $error("unmatched board selected");
   chk_cs_match: assert property (settled |-> ctrl_cs_n_out == !cs) else $error("cs wrong");
   chk_reg_pass: assert property (settled ##0 cs |-> ctrl_reg_sel_out == bus_in.addr[1:0])
      else $error("reg select wrong");
   chk_read_gate: assert property (settled |-> ctrl_rd_n_out == !(cs && bus_in.dbin && bus_in.inp))
      else $error("read wrong");
   chk_write_gate: assert property (settled |-> ctrl_wr_n_out == !(cs && !bus_in.wr_n && bus_in.outp))
      else $error("write wrong");
   chk_aux_sel: assert property (settled |-> aux_sel_out ==
      (hit && bus_in.addr[2:0] == 3'h4 && !bus_in.wr_n && bus_in.outp)) else $error("aux select wrong");
   chk_code_dec: assert property (settled |-> dec == ~({3{aux_sel_out}} & (3'h1 << bus_in.dout[2:0])))
      else $error("code decode wrong");
   chk_reset_pin: assert property (drive_reset_n_out == dec[0]) else $error("drive reset wrong");
endmodule
bind io_port_select_decoder io_port_select_decoder_monitor i_mon(.*);
`default_nettype wire

// >>> test/host_bus_model.sv
// Purpose: host side of the port bus
// Assumes: lines change at the falling edge
// Notes: released address and data lines show the inverse of the last value; strobes return to idle
`timescale 1ns/1ps
`default_nettype none
module host_bus_model import port_decode_pkg::*; (input wire logic ref_clk_in, output var host_bus_t bus_out);
   initial bus_out = {16'h0000, 4'h2};
   task automatic io(input logic [7:0] a, input logic [7:0] d, input logic rd);
      @(negedge ref_clk_in);
      bus_out = {a, d, rd, rd, rd, !rd};
      repeat (12) @(negedge ref_clk_in);
   endtask
   task automatic idle();
      bus_out = {~bus_out.addr, ~bus_out.dout, 4'h2};
      repeat (2) @(negedge ref_clk_in);
   endtask
endmodule
`default_nettype wire

// >>> test/io_port_select_decoder_test.sv
// Purpose: decode sweep over all offsets, with codes 0..5 written to offset 4
// Assumes: host model holds each access 12 cycles and each idle 2
// Notes: one group in eight misses the base
`timescale 1ns/1ps
`default_nettype none
module io_port_select_decoder_test;
   import port_decode_pkg::*;
   logic ref_clk_in = 1'b0, arst_n_in = 1'b0, rd, cs, aux;
   logic [4:0] base_sw_in = 5'h00;
   logic [7:0] d;
   logic [9:0] exp_q[$];
   wire host_bus_t bus_in;
   wire logic [9:0] o;
   int fail_count = 0, check_count = 0;
   integer seed = 32'hA5B6;
   event done_e;
   host_bus_model i_host(.ref_clk_in, .bus_out(bus_in));
   io_port_select_decoder i_dut(.ref_clk_in, .arst_n_in, .bus_in, .base_sw_in, .ctrl_cs_n_out(o[9]),
      .ctrl_rd_n_out(o[8]), .ctrl_wr_n_out(o[7]), .ctrl_reg_sel_out(o[6:5]), .aux_sel_out(o[4]),
      .decoder_out_five_n_out(o[3]), .decoder_out_six_n_out(o[2]), .decoder_out_seven_n_out(o[1]),
      .drive_reset_n_out(o[0]));
   task automatic compare(input logic [9:0] e);
      check_count++;
      if (o !== e) begin
         fail_count++;
         $display("Error outputs expected %h seen %h", e, o);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial forever #2.5 ref_clk_in = ~ref_clk_in;
   initial forever @(done_e) compare(exp_q.pop_front());
   initial begin
      #20000 fail_count++;
      final_report();
   end
   initial begin
      repeat (5) @(negedge ref_clk_in);
      arst_n_in = 1'b1;
      repeat (5) @(negedge ref_clk_in);
      for (int i = 0; i < 64; i++) begin
         base_sw_in = 5'($random(seed));
         d = {5'($random(seed)), i[5:3]};
         rd = i[5:3] == 3'h7 || (!i[2] && i[3]);
         cs = i[5:3] != 3'h6 && !i[2];
         aux = i[5:3] != 3'h6 && i[2:0] == 3'h4 && !rd;
         exp_q.push_back({!cs, !(cs && rd), !(cs && !rd), cs ? i[1:0] : 2'h0, aux,
            ~({3{aux}} & 3'(1 << d[2:0])), !(aux && d[2:0] == 3'h0)});
         // Near misses flip one compared bit only
         i_host.io({i[5:3] == 3'h6 ? base_sw_in ^ 5'(1 << i[1:0]) : base_sw_in, i[2:0]}, d, rd);
         -> done_e;
         i_host.idle();
      end
      $display("decode sweep done");
      // Mid-run reset must drop every output at once, then decode must come back
      @(negedge ref_clk_in);
      arst_n_in = 1'b0;
      @(negedge ref_clk_in);
      exp_q.push_back(10'h38F);
      -> done_e;
      arst_n_in = 1'b1;
      repeat (5) @(negedge ref_clk_in);
      d = 8'hF8;
      exp_q.push_back(10'h39C);
      i_host.io({base_sw_in, 3'h4}, d, 1'b0);
      -> done_e;
      i_host.idle();
      $display("mid-run reset done");
      final_report();
   end
endmodule
`default_nettype wire
